/* File: hw/pga_port_group.sv */
// Open-drain ports A and B and the input-only port with alternate functions
// How it works
// R1: Port A at 73H, latch write, mode-dependent read
// R2: Per-bit direction; zero means input, reads pin
// R3: Output bits drive latch; read returns latch
// R4: Per-bit pull-up enable on port A
// R5: Reset clears port A direction and latch
// R6: Latch kept when direction returns to input
// R7: Serial enable takes pins zero to two
// R8: Timer select takes pin three
// R9: Toggle output one at reset, inverts on match
// R10: Pin three's function selected independently; pins zero to two switch together on serial enable
// R11: Read source per alternate function and clock
// R12: Port B at 6EH with group direction
// R13: Port B drives latch when output, reads accordingly
// R14: Port B group pull-up bit
// R15: Reset clears port B direction and latch
// R16: Two-bit input port at 6FH, high bits zero
// R17: Writes to input-only port ignored
// R18: Any analog select makes bit one read zero
// R19: Analog select bit switches channel pin
// R20: Open-drain: pull low on zero, release on one
`timescale 1ns/1ns
`default_nettype none
module pga_port_group (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data-memory access
  input wire logic [6:0] dmAddr,
  input wire logic dmWrite,
  input wire logic dmRead,
  input wire logic [3:0] dmWdata,
  output logic [3:0] dmRdata,
  // Register-file access
  input wire logic [6:0] rfAddr,
  input wire logic rfWrite,
  input wire logic rfRead,
  input wire logic [3:0] rfWdata,
  output logic [3:0] rfRdata,
  // Serial interface side
  input wire logic serialClkInternal,
  input wire logic serialClkOut,
  input wire logic serialDataOut,
  output logic serialClkIn,
  output logic serialDataIn,
  // Timer 1 side
  input wire logic timer1Reset,
  input wire logic timer1Match,
  // Port A pins
  input wire logic [3:0] portAIn,
  output logic [3:0] portAOut,
  output logic [3:0] portAOe_n,
  output logic [3:0] portAPullup,
  // Port B pins
  input wire logic [3:0] portBIn,
  output logic [3:0] portBOut,
  output logic [3:0] portBOe_n,
  output logic [3:0] portBPullup,
  // Input-only port pins and converter side
  input wire logic [1:0] inputOnlyIn,
  output logic standbyReleaseInput,
  output logic vrefPinSelect,
  output logic [3:0] analogPinEnable
);
  import pga_pkg::*;

  logic [3:0] portALatch;
  logic [3:0] portABitDirection;
  logic [3:0] portABitPullup;
  logic [3:0] portBLatch;
  logic portBGroupDirection;
  logic portBGroupPullup;
  logic serialPinsEnable;
  logic timerToggleOutSelect;
  logic timerToggleOutput;
  logic [3:0] analogInputSelect;
  logic [3:0] portALevel;
  logic [3:0] portBLevel;
  logic [1:0] inputOnlyLevel;
  logic [3:0] portADrive;
  logic [3:0] portAValue;
  logic [3:0] portAReadLatch;
  logic [3:0] next_dmRdata;
  logic [3:0] next_rfRdata;

  function automatic logic hit(input logic [6:0] addr, input logic [6:0] reg_addr,
                               input logic strobe);
    hit = strobe && (addr == reg_addr);
  endfunction

  pga_pin_sync #(.WIDTH(4)) u_sync_a (
    .clk(clk),
    .rst_n(rst_n),
    .pinRaw(portAIn),
    .pinLevel(portALevel)
  );
  pga_pin_sync #(.WIDTH(4)) u_sync_b (
    .clk(clk),
    .rst_n(rst_n),
    .pinRaw(portBIn),
    .pinLevel(portBLevel)
  );
  pga_pin_sync #(.WIDTH(2)) u_sync_f (
    .clk(clk),
    .rst_n(rst_n),
    .pinRaw(inputOnlyIn),
    .pinLevel(inputOnlyLevel)
  );

  // Output latches; direction is not consulted so the latch survives [R6]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portALatch <= PGA_RST_NIBBLE; // [R5]
      portBLatch <= PGA_RST_NIBBLE; // [R15]
    end else begin
      if (hit(dmAddr, PGA_ADDR_PORT_A, dmWrite)) begin
        portALatch <= dmWdata; // [R1]
      end
      if (hit(dmAddr, PGA_ADDR_PORT_B, dmWrite)) begin
        portBLatch <= dmWdata; // [R12]
      end
      // Input-only address has no storage, writes fall through [R17]
    end
  end

  // Register-file control bits owned by this block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portABitDirection <= PGA_RST_NIBBLE; // [R5]
      portABitPullup <= PGA_RST_NIBBLE;
      portBGroupDirection <= PGA_RST_BIT; // [R15]
      portBGroupPullup <= PGA_RST_BIT;
      serialPinsEnable <= PGA_RST_BIT;
      timerToggleOutSelect <= PGA_RST_BIT;
      analogInputSelect <= PGA_RST_NIBBLE;
    end else if (rfWrite) begin
      unique case (rfAddr)
        PGA_RF_PORT_A_DIR: portABitDirection <= rfWdata; // [R2]
        PGA_RF_PORT_A_PULLUP: portABitPullup <= rfWdata; // [R4]
        PGA_RF_GROUP_DIR: portBGroupDirection <= rfWdata[PGA_BIT_PORT_B_GROUP]; // [R12]
        PGA_RF_GROUP_PULLUP: portBGroupPullup <= rfWdata[PGA_BIT_PORT_B_GROUP]; // [R14]
        PGA_RF_ALT_SELECT: begin
          serialPinsEnable <= rfWdata[PGA_BIT_SERIAL_EN]; // [R7]
          timerToggleOutSelect <= rfWdata[PGA_BIT_TIMER_SEL]; // [R8]
        end
        PGA_RF_ANALOG_SELECT: analogInputSelect <= rfWdata; // [R19]
        default: ;
      endcase
    end
  end

  // Toggle output; a match in the reset cycle loses to the reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerToggleOutput <= PGA_RST_TOGGLE;
    end else if (timer1Reset) begin
      timerToggleOutput <= PGA_RST_TOGGLE; // [R9]
    end else if (timer1Match) begin
      timerToggleOutput <= ~timerToggleOutput; // [R9]
    end
  end

  // Per-pin function selection for port A
  always_comb begin
    portADrive = portABitDirection; // [R3]
    portAValue = portALatch;
    portAReadLatch = portABitDirection; // [R2] [R3]
    if (serialPinsEnable) begin // [R7] [R10]
      portADrive[PGA_PIN_SCK] = serialClkInternal;
      portAValue[PGA_PIN_SCK] = serialClkOut;
      portAReadLatch[PGA_PIN_SCK] = serialClkInternal; // [R11]
      portADrive[PGA_PIN_SO] = 1'b1;
      portAValue[PGA_PIN_SO] = serialDataOut;
      portAReadLatch[PGA_PIN_SO] = 1'b1; // [R11]
      portADrive[PGA_PIN_SI] = 1'b0;
      portAReadLatch[PGA_PIN_SI] = 1'b0; // [R11]
    end
    if (timerToggleOutSelect) begin // [R8] [R10]
      portADrive[PGA_PIN_TMO] = 1'b1;
      portAValue[PGA_PIN_TMO] = timerToggleOutput;
      portAReadLatch[PGA_PIN_TMO] = 1'b1; // [R11]
    end
  end

  // Open-drain pads: only a driven zero enables the pad [R20]
  assign portAOut = 4'h0;
  assign portAOe_n = ~(portADrive & ~portAValue); // [R20]
  assign portAPullup = portABitPullup; // [R4]
  assign portBOut = 4'h0;
  assign portBOe_n = ~({4{portBGroupDirection}} & ~portBLatch); // [R13] [R20]
  assign portBPullup = {4{portBGroupPullup}}; // [R14]

  assign serialClkIn = portALevel[PGA_PIN_SCK];
  assign serialDataIn = portALevel[PGA_PIN_SI];
  assign standbyReleaseInput = inputOnlyLevel[0];
  assign vrefPinSelect = |analogInputSelect; // [R18]
  assign analogPinEnable = analogInputSelect; // [R19]

  // Read multiplexers
  always_comb begin
    next_dmRdata = 4'h0;
    unique case (dmAddr)
      PGA_ADDR_PORT_A:
        next_dmRdata = (portAReadLatch & portALatch) | (~portAReadLatch & portALevel); // [R1]
      PGA_ADDR_PORT_B:
        next_dmRdata = portBGroupDirection ? portBLatch : portBLevel; // [R13]
      PGA_ADDR_INPUT_ONLY: begin
        next_dmRdata = {2'h0, inputOnlyLevel}; // [R16]
        if (vrefPinSelect) begin
          next_dmRdata[PGA_BIT_VREF_PIN] = 1'b0; // [R18]
        end
      end
      default: next_dmRdata = 4'h0;
    endcase
  end

  always_comb begin
    next_rfRdata = 4'h0;
    unique case (rfAddr)
      PGA_RF_PORT_A_DIR: next_rfRdata = portABitDirection;
      PGA_RF_PORT_A_PULLUP: next_rfRdata = portABitPullup;
      PGA_RF_GROUP_DIR: next_rfRdata[PGA_BIT_PORT_B_GROUP] = portBGroupDirection;
      PGA_RF_GROUP_PULLUP: next_rfRdata[PGA_BIT_PORT_B_GROUP] = portBGroupPullup;
      PGA_RF_ALT_SELECT: begin
        next_rfRdata[PGA_BIT_SERIAL_EN] = serialPinsEnable;
        next_rfRdata[PGA_BIT_TIMER_SEL] = timerToggleOutSelect;
      end
      PGA_RF_ANALOG_SELECT: next_rfRdata = analogInputSelect;
      default: next_rfRdata = 4'h0;
    endcase
  end

  // Read data held from flip-flops until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmRdata <= 4'h0;
    end else if (dmRead) begin
      dmRdata <= next_dmRdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rfRdata <= 4'h0;
    end else if (rfRead) begin
      rfRdata <= next_rfRdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_port_a_write: assert property (
    hit(dmAddr, PGA_ADDR_PORT_A, dmWrite) |=> portALatch == $past(dmWdata)) // [R1]
    else $error("port A latch did not take the write");
  a_input_pin_read: assert property (
    dmRead && dmAddr == PGA_ADDR_PORT_A && !serialPinsEnable && !timerToggleOutSelect
    && portABitDirection == 4'h0 |=> dmRdata == $past(portALevel)) // [R2]
    else $error("input port A read did not return pins");
  a_output_latch_read: assert property (
    dmRead && dmAddr == PGA_ADDR_PORT_A && !serialPinsEnable && !timerToggleOutSelect
    && portABitDirection == 4'hf |=> dmRdata == $past(portALatch)) // [R3]
    else $error("output port A read did not return latch");
  a_pullup_follow: assert property (portAPullup == portABitPullup
    && portBPullup == {4{portBGroupPullup}}) // [R4] [R14]
    else $error("pull-up enables mismatch");
  a_latch_kept: assert property (
    !hit(dmAddr, PGA_ADDR_PORT_A, dmWrite) |=> $stable(portALatch)) // [R6]
    else $error("port A latch changed without a write");
  a_serial_release_si: assert property (
    serialPinsEnable |-> portAOe_n[PGA_PIN_SI] && portAOe_n[PGA_PIN_SO] == serialDataOut) // [R7]
    else $error("serial pins not handed over");
  a_toggle_pin: assert property (
    timerToggleOutSelect |-> portAOe_n[PGA_PIN_TMO] == timerToggleOutput) // [R8]
    else $error("pin three not following toggle output");
  a_toggle_invert: assert property (
    timer1Match && !timer1Reset |=> timerToggleOutput != $past(timerToggleOutput)) // [R9]
    else $error("toggle output did not invert on match");
  a_toggle_reset: assert property (timer1Reset |=> timerToggleOutput) // [R9]
    else $error("toggle output not one after timer reset");
  a_port_b_drive: assert property (
    !portBGroupDirection |-> portBOe_n == 4'hf) // [R13] [R20]
    else $error("port B driving while input");
  a_input_only_read: assert property (
    dmRead && dmAddr == PGA_ADDR_INPUT_ONLY |=> dmRdata[3:2] == 2'h0
    && (!$past(vrefPinSelect) || !dmRdata[1])) // [R16] [R18]
    else $error("input-only port read wrong");

  c_serial_mode: cover property (serialPinsEnable && serialClkInternal);
  c_toggle_run: cover property (timerToggleOutSelect && timer1Match ##1 timer1Match);
  c_vref_read: cover property (vrefPinSelect && dmRead && dmAddr == PGA_ADDR_INPUT_ONLY);
endmodule // pga_port_group
`default_nettype wire

/* File: hw/pga_pkg.sv */
// Constants for the three-port pin group with alternate functions
package pga_pkg;
  // Data-memory addresses in bank zero
  localparam logic [6:0] PGA_ADDR_PORT_B = 7'h6e;
  localparam logic [6:0] PGA_ADDR_INPUT_ONLY = 7'h6f;
  localparam logic [6:0] PGA_ADDR_PORT_A = 7'h73;
  // Register-file addresses
  localparam logic [6:0] PGA_RF_ALT_SELECT = 7'h0b;
  localparam logic [6:0] PGA_RF_GROUP_PULLUP = 7'h0c;
  localparam logic [6:0] PGA_RF_PORT_A_PULLUP = 7'h0d;
  localparam logic [6:0] PGA_RF_ANALOG_SELECT = 7'h1b;
  localparam logic [6:0] PGA_RF_PORT_A_DIR = 7'h2b;
  localparam logic [6:0] PGA_RF_GROUP_DIR = 7'h2c;
  // Field positions
  localparam int PGA_BIT_SERIAL_EN = 0;
  localparam int PGA_BIT_TIMER_SEL = 3;
  localparam int PGA_BIT_PORT_B_GROUP = 2;
  localparam int PGA_BIT_VREF_PIN = 1;
  localparam int PGA_PIN_SCK = 0;
  localparam int PGA_PIN_SO = 1;
  localparam int PGA_PIN_SI = 2;
  localparam int PGA_PIN_TMO = 3;
  // Reset values
  localparam logic [3:0] PGA_RST_NIBBLE = 4'h0;
  localparam logic PGA_RST_BIT = 1'b0;
  localparam logic PGA_RST_TOGGLE = 1'b1;
  localparam logic [1:0] PGA_RST_INPUT_ONLY = 2'h0;
  // Synchroniser depth
  localparam int PGA_SYNC_STAGES = 3;
endpackage

/* File: hw/pga_pin_sync.sv */
// Three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pga_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pinRaw,
  output logic [WIDTH-1:0] pinLevel
);
  import pga_pkg::*;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [PGA_SYNC_STAGES-1:0] stage;
      logic level;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage <= '0;
        end else begin
          stage <= {stage[PGA_SYNC_STAGES-2:0], pinRaw[i]};
        end
      end
      // First stage feeds only the second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          level <= 1'b0;
        end else if (stage[1] == stage[2]) begin
          level <= stage[2];
        end
      end
      // One process per bit owns its own flop, the port only collects them
      assign pinLevel[i] = level;
    end
  endgenerate
endmodule // pga_pin_sync
`default_nettype wire

/* File: sim/pga_pin_model.sv */
// Pad model: open-drain resolution with pull-ups and outside drivers
`timescale 1ns/1ns
`default_nettype none
module pga_pin_model (
  // Clock
  input wire logic clk,
  // Device pin controls
  input wire logic [3:0] oeN,
  input wire logic [3:0] pullEn,
  // Outside driver
  input wire logic [3:0] extEn,
  input wire logic [3:0] extVal,
  // Resolved pad level
  output logic [3:0] pad
);
  logic [3:0] floatPat = 4'h5;
  // Undriven pads wander so a stale level never passes for a real one
  always @(posedge clk) floatPat <= ~floatPat;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!oeN[i]) pad[i] = 1'b0;
      else if (extEn[i]) pad[i] = extVal[i];
      else if (pullEn[i]) pad[i] = 1'b1;
      else pad[i] = floatPat[i];
    end
  end
endmodule // pga_pin_model
`default_nettype wire

/* File: sim/test_pga_port_group.sv */
// Self-checking bench for the three-port pin group
`timescale 1ns/1ns
`default_nettype none
module test_pga_port_group;
  import pga_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] dmAddr = 7'h00, rfAddr = 7'h00;
  logic dmWrite = 1'b0, dmRead = 1'b0, rfWrite = 1'b0, rfRead = 1'b0;
  logic [3:0] dmWdata = 4'h0, rfWdata = 4'h0, extEnA = 4'h0, extValA = 4'h0;
  logic [3:0] extEnB = 4'h0, extValB = 4'h0;
  logic serialClkInternal = 1'b0, serialClkOut = 1'b1, serialDataOut = 1'b1;
  logic timer1Reset = 1'b0, timer1Match = 1'b0;
  logic [1:0] inputOnlyIn = 2'h0;
  logic [3:0] dmRdata, rfRdata, portAIn, portAOut, portAOe_n, portAPullup;
  logic [3:0] portBIn, portBOut, portBOe_n, portBPullup, analogPinEnable;
  logic serialClkIn, serialDataIn, standbyReleaseInput, vrefPinSelect;
  int miscompares = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  pga_port_group dut (.clk, .rst_n, .dmAddr, .dmWrite, .dmRead, .dmWdata, .dmRdata,
    .rfAddr, .rfWrite, .rfRead, .rfWdata, .rfRdata, .serialClkInternal, .serialClkOut,
    .serialDataOut, .serialClkIn, .serialDataIn, .timer1Reset, .timer1Match,
    .portAIn, .portAOut, .portAOe_n, .portAPullup, .portBIn, .portBOut, .portBOe_n,
    .portBPullup, .inputOnlyIn, .standbyReleaseInput, .vrefPinSelect, .analogPinEnable);
  pga_pin_model padA (.clk(clk), .oeN(portAOe_n), .pullEn(portAPullup), .extEn(extEnA),
    .extVal(extValA), .pad(portAIn));
  pga_pin_model padB (.clk(clk), .oeN(portBOe_n), .pullEn(portBPullup), .extEn(extEnB),
    .extVal(extValB), .pad(portBIn));

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One access; strobes last exactly one rising edge
  task automatic acc(input logic rf, input logic wr, input logic [6:0] a,
                     input logic [3:0] d, output logic [3:0] q);
    @(negedge clk);
    if (rf) {rfAddr, rfWdata, rfWrite, rfRead} = {a, d, wr, !wr};
    else {dmAddr, dmWdata, dmWrite, dmRead} = {a, d, wr, !wr};
    @(negedge clk);
    {rfWrite, rfRead, dmWrite, dmRead} = 4'h0;
    q = rf ? rfRdata : dmRdata;
  endtask

  task automatic wr(input logic rf, input logic [6:0] a, input logic [3:0] d);
    logic [3:0] q;
    acc(rf, 1'b1, a, d, q);
  endtask

  task automatic rd(input logic rf, input logic [6:0] a, input logic [3:0] exp);
    logic [3:0] q;
    acc(rf, 1'b0, a, 4'h0, q);
    chk(q, exp);
  endtask

  // Synchroniser needs a few edges before pads are seen
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  task automatic pulse(input logic m);
    @(negedge clk);
    if (m) timer1Match = 1'b1;
    else timer1Reset = 1'b1;
    @(negedge clk);
    timer1Match = 1'b0;
    timer1Reset = 1'b0;
  endtask

  task automatic t_reset();
    rd(1'b1, PGA_RF_PORT_A_DIR, 4'h0);
    rd(1'b1, PGA_RF_GROUP_DIR, 4'h0);
    chk(portAOe_n, 4'hf);
    chk(portBOe_n, 4'hf);
    chk(portAOut, 4'h0);
    chk(portBOut, 4'h0);
    wr(1'b1, PGA_RF_PORT_A_DIR, 4'hf);
    chk(portAOe_n, 4'h0);
    wr(1'b1, PGA_RF_PORT_A_DIR, 4'h0);
    wr(1'b1, PGA_RF_GROUP_DIR, 4'h4);
    chk(portBOe_n, 4'h0);
    wr(1'b1, PGA_RF_GROUP_DIR, 4'h0);
  endtask

  task automatic t_port_a();
    {extEnA, extValA} = {4'hf, 4'hc};
    wr(1'b0, PGA_ADDR_PORT_A, 4'h5);
    wr(1'b1, PGA_RF_PORT_A_DIR, 4'h3);
    chk(portAOe_n, 4'hd);
    settle();
    rd(1'b0, PGA_ADDR_PORT_A, 4'hd);
    wr(1'b1, PGA_RF_PORT_A_DIR, 4'h0);
    settle();
    rd(1'b0, PGA_ADDR_PORT_A, 4'hc);
    wr(1'b1, PGA_RF_PORT_A_DIR, 4'hf);
    chk(portAOe_n, 4'h5);
    rd(1'b0, PGA_ADDR_PORT_A, 4'h5);
    wr(1'b1, PGA_RF_PORT_A_DIR, 4'h0);
  endtask

  task automatic t_pullups();
    wr(1'b1, PGA_RF_PORT_A_PULLUP, 4'h6);
    chk(portAPullup, 4'h6);
    rd(1'b1, PGA_RF_PORT_A_PULLUP, 4'h6);
    wr(1'b1, PGA_RF_GROUP_PULLUP, 4'h4);
    chk(portBPullup, 4'hf);
    wr(1'b1, PGA_RF_GROUP_PULLUP, 4'hb);
    chk(portBPullup, 4'h0);
  endtask

  task automatic t_port_b();
    {extEnB, extValB} = {4'hf, 4'h9};
    wr(1'b0, PGA_ADDR_PORT_B, 4'h6);
    settle();
    rd(1'b0, PGA_ADDR_PORT_B, 4'h9);
    wr(1'b1, PGA_RF_GROUP_DIR, 4'h4);
    chk(portBOe_n, 4'h6);
    rd(1'b0, PGA_ADDR_PORT_B, 4'h6);
    wr(1'b1, PGA_RF_GROUP_DIR, 4'h0);
    chk(portBOe_n, 4'hf);
  endtask

  task automatic t_serial();
    {extEnA, extValA} = {4'hd, 4'h4};
    {serialClkInternal, serialClkOut, serialDataOut} = 3'b100;
    wr(1'b0, PGA_ADDR_PORT_A, 4'hf);
    wr(1'b1, PGA_RF_ALT_SELECT, 4'h1);
    chk(portAOe_n, 4'hc);
    settle();
    rd(1'b0, PGA_ADDR_PORT_A, 4'h7);
    chk({3'h0, serialDataIn}, 4'h1);
    serialClkInternal = 1'b0;
    {extEnA, extValA} = {4'hf, 4'h5};
    settle();
    chk(portAOe_n, 4'hd);
    chk({3'h0, serialClkIn}, 4'h1);
    rd(1'b0, PGA_ADDR_PORT_A, 4'h7);
  endtask

  task automatic t_timer();
    wr(1'b0, PGA_ADDR_PORT_A, 4'h0);
    extValA = 4'h8;
    wr(1'b1, PGA_RF_ALT_SELECT, 4'h8);
    pulse(1'b0);
    chk(portAOe_n, 4'hf);
    pulse(1'b1);
    chk(portAOe_n, 4'h7);
    pulse(1'b0);
    chk(portAOe_n, 4'hf);
    pulse(1'b1);
    pulse(1'b1);
    chk(portAOe_n, 4'hf);
    settle();
    rd(1'b0, PGA_ADDR_PORT_A, 4'h0);
  endtask

  task automatic t_input_only();
    inputOnlyIn = 2'h3;
    settle();
    rd(1'b0, PGA_ADDR_INPUT_ONLY, 4'h3);
    chk({3'h0, standbyReleaseInput}, 4'h1);
    wr(1'b0, PGA_ADDR_INPUT_ONLY, 4'hc);
    rd(1'b0, PGA_ADDR_INPUT_ONLY, 4'h3);
    wr(1'b1, PGA_RF_ANALOG_SELECT, 4'h4);
    chk(analogPinEnable, 4'h4);
    chk({3'h0, vrefPinSelect}, 4'h1);
    rd(1'b0, PGA_ADDR_INPUT_ONLY, 4'h1);
    wr(1'b1, PGA_RF_ANALOG_SELECT, 4'h0);
    rd(1'b0, PGA_ADDR_INPUT_ONLY, 4'h3);
    rd(1'b0, 7'h50, 4'h0);
  endtask

  // Reset in mid-run must clear latches that were written before it
  task automatic t_mid_reset();
    wr(1'b0, PGA_ADDR_PORT_A, 4'ha);
    wr(1'b0, PGA_ADDR_PORT_B, 4'ha);
    wr(1'b1, PGA_RF_GROUP_DIR, 4'h4);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(portAOe_n, 4'hf);
    chk(portBOe_n, 4'hf);
    wr(1'b1, PGA_RF_PORT_A_DIR, 4'hf);
    wr(1'b1, PGA_RF_GROUP_DIR, 4'h4);
    chk(portAOe_n, 4'h0);
    chk(portBOe_n, 4'h0);
    rd(1'b0, PGA_ADDR_PORT_A, 4'h0);
    rd(1'b0, PGA_ADDR_PORT_B, 4'h0);
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_port_a();
    t_pullups();
    t_port_b();
    t_serial();
    t_timer();
    t_input_only();
    t_mid_reset();
    wrap_up();
  end

  // Whole run is about 155 cycles; this is far beyond it
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule // test_pga_port_group
`default_nettype wire
